// ==== rtl/iep_pkg.sv ====
// constants, register map and field layout of the interrupt enable/priority block
//
// Contract
// RULE_01: poll all request flags each machine cycle using values sampled at state5_phase2.
// RULE_02: blocked requests are not remembered; a vanished flag is not serviced later.
// RULE_03: acknowledge forces a long_subroutine_call: push PC only, load source vector.
// RULE_04: vectoring to timer 0 or timer 1 clears that timer's overflow flag.
// RULE_05: external flags cleared on acknowledge only when edge-triggered, never in level mode.
// RULE_06: no other request flag is cleared by acknowledge; software clears the rest.
// RULE_07: return_from_interrupt clears the active level latch, then core pops PC.
// RULE_08: global_irq_enable bit 7 gates all sources; zero blocks every interrupt.
// RULE_09: primary enable bits 6..0: converter, twowire, async, tmr1, ext1, tmr0, ext0.
// RULE_10: timer2 enable: bit7 overflow, bits 6..4 match 2..0, bits 3..0 capture 3..0.
// RULE_11: each individual enable bit: zero disables its source, one enables it.
// RULE_12: primary priority gives one-bit level per source, same layout; bit 7 reserved.
// RULE_13: timer2_control bit7 wide overflow select, bit6 byte select, bit4 byte flag.
// RULE_14: converter_done_flag is not cleared on acknowledge; software clears it.
// RULE_15: high level preempts low service; same or lower level waits for return.
// RULE_16: equal-level requests in one poll resolved by fixed order, lowest index first.
package iep_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_ENABLE_PRIMARY = 8'hA8;
  localparam logic [7:0] OFS_PRIORITY_PRIMARY = 8'hB8;
  localparam logic [7:0] OFS_ENABLE_TIMER2 = 8'hE8;
  localparam logic [7:0] OFS_TIMER2_CONTROL = 8'hEC;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF4;
  localparam logic [7:0] OFS_ACTIVE_STATE = 8'hF8;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_STATUS = 3'h0;
  // field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] PRIO_WRITE_MASK = 8'h7F;
  localparam int T2C_WIDE_SEL_BIT = 7;
  localparam int T2C_BYTE_SEL_BIT = 6;
  localparam int T2C_BYTE_FLAG_BIT = 4;
  // status register events
  localparam int ST_W = 3;
  localparam int ST_ACK = 0;
  localparam int ST_RETURN_FROM_INTERRUPT = 1;
  localparam int ST_BYTE_OVF = 2;
  // sources, in fixed resolution order
  localparam int NUM_SRC = 15;
  localparam int SRC_W = 4;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TMR0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TMR1 = 4'h3;
  // machine cycle timing
  localparam logic [3:0] CLK_PER_MCYCLE = 4'hC;
  localparam logic [3:0] POLL_PHASE = 4'h0;
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  // vector generation
  localparam logic [15:0] VEC_BASE = 16'h0003;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ==== rtl/iep_interrupt_ctrl.sv ====
// interrupt enable, priority and acknowledge controller with an ahb-lite register slave
`timescale 1ns/1ps
module iep_interrupt_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // peripheral request flags
  input wire logic ext0Flag,
  input wire logic tmr0Flag,
  input wire logic ext1Flag,
  input wire logic tmr1Flag,
  input wire logic asyncSerialFlag,
  input wire logic twowireFlag,
  input wire logic converterDoneFlag,
  input wire logic [3:0] t2CaptureFlag,
  input wire logic [2:0] t2MatchFlag,
  input wire logic t2WideOverflowFlag,
  input wire logic t2ByteOverflowEvent,
  input wire logic ext0EdgeMode,
  input wire logic ext1EdgeMode,
  // flag clears toward peripherals
  output logic tmr0FlagClear,
  output logic tmr1FlagClear,
  output logic ext0FlagClear,
  output logic ext1FlagClear,
  // cpu core side
  input wire logic pollBlocked,
  input wire logic callTaken,
  input wire logic retiDone,
  output logic callRequest,
  output logic [15:0] callVector,
  output logic [iep_pkg::SRC_W-1:0] callSource,
  output logic [1:0] activeLevel,
  output logic machineCycleStart,
  output logic [7:0] t2Config,
  output logic irq
);
  import iep_pkg::*;

  logic [3:0] phaseCnt;
  logic [7:0] enablePrimary;
  logic [7:0] priorityPrimary;
  logic [7:0] enableTimer2;
  logic [7:0] timer2Control;
  logic [ST_W-1:0] irqStatus;
  logic [ST_W-1:0] irqMask;
  logic [NUM_SRC-1:0] sampledReq;
  logic [NUM_SRC-1:0] rawReq;
  logic [NUM_SRC-1:0] enableVec;
  logic [NUM_SRC-1:0] levelVec;
  logic [NUM_SRC-1:0] eligible;
  logic [SRC_W:0] hiPick;
  logic [SRC_W:0] loPick;
  logic winFound;
  logic winLevel;
  logic [SRC_W-1:0] winIdx;
  logic callLevel;
  logic [1:0] next_activeLevel;
  logic [ST_W-1:0] statusSet;
  logic dataPhase;
  logic dataWrite;
  logic [7:0] dataAddr;
  logic [7:0] readByte;
  logic addrAccept;
  logic regWrite;
  logic sampleStrobe;
  logic pollStrobe;
  logic ackFire;
  logic t2Overflow;

  // lowest set index wins; msb of result tells whether any bit was set
  function automatic logic [SRC_W:0] pickFirst(input logic [NUM_SRC-1:0] vec);
    logic [SRC_W:0] res;
    res = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, i[SRC_W-1:0]};
      end
    end
    return res;
  endfunction

  // register select for a write landing in the data phase
  function automatic logic regHit(input logic [7:0] ofs);
    return regWrite && (dataAddr == ofs);
  endfunction

  // machine cycle divider, one poll and one sample point per cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseCnt <= POLL_PHASE;
      machineCycleStart <= 1'b0;
    end else begin
      if (phaseCnt == CLK_PER_MCYCLE - 4'h1) begin
        phaseCnt <= POLL_PHASE;
      end else begin
        phaseCnt <= phaseCnt + 4'h1;
      end
      machineCycleStart <= (phaseCnt == CLK_PER_MCYCLE - 4'h1);
    end
  end

  assign sampleStrobe = (phaseCnt == SAMPLE_PHASE);
  assign pollStrobe = (phaseCnt == POLL_PHASE);

  // request vector in fixed order, t2 overflow merged through its selects
  assign t2Overflow = (timer2Control[T2C_WIDE_SEL_BIT] & t2WideOverflowFlag) |
                      (timer2Control[T2C_BYTE_SEL_BIT] & timer2Control[T2C_BYTE_FLAG_BIT]); // RULE_13
  assign rawReq = {t2Overflow, t2MatchFlag, t2CaptureFlag, converterDoneFlag, twowireFlag,
                   asyncSerialFlag, tmr1Flag, ext1Flag, tmr0Flag, ext0Flag};

  // flags captured at the state5 phase2 point, refreshed every cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampledReq <= '0;
    end else if (sampleStrobe) begin
      sampledReq <= rawReq; // RULE_01 RULE_02
    end
  end

  // enables, global gate and levels
  assign enableVec = {enableTimer2, enablePrimary[6:0]} &
                     {NUM_SRC{enablePrimary[GLOBAL_EN_BIT]}}; // RULE_08 RULE_09 RULE_10 RULE_11
  assign levelVec = {8'h00, priorityPrimary[6:0]}; // RULE_12
  assign eligible = sampledReq & enableVec;
  assign hiPick = pickFirst(eligible & levelVec); // RULE_16
  assign loPick = pickFirst(eligible & ~levelVec); // RULE_16

  // level gating: high needs no high active, low needs nothing active
  always_comb begin
    winFound = 1'b0;
    winLevel = 1'b0;
    winIdx = '0;
    if (hiPick[SRC_W] && !activeLevel[1]) begin
      winFound = 1'b1; // RULE_15
      winLevel = 1'b1;
      winIdx = hiPick[SRC_W-1:0];
    end else if (loPick[SRC_W] && (activeLevel == 2'b00)) begin
      winFound = 1'b1; // RULE_15
      winLevel = 1'b0;
      winIdx = loPick[SRC_W-1:0];
    end
  end

  assign ackFire = callTaken & callRequest;

  // forced call request toward the core with source vector
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      callRequest <= 1'b0;
      callVector <= VEC_BASE;
      callSource <= '0;
      callLevel <= 1'b0;
    end else if (ackFire) begin
      callRequest <= 1'b0;
    end else if (pollStrobe && !pollBlocked && !callRequest && winFound) begin
      callRequest <= 1'b1; // RULE_03
      callSource <= winIdx;
      callLevel <= winLevel;
      callVector <= VEC_BASE + {9'h000, winIdx, 3'b000}; // RULE_03
    end
  end

  // active level latches: return clears the highest, acknowledge sets
  always_comb begin
    next_activeLevel = activeLevel;
    if (retiDone) begin
      if (activeLevel[1]) begin
        next_activeLevel[1] = 1'b0; // RULE_07
      end else begin
        next_activeLevel[0] = 1'b0; // RULE_07
      end
    end
    if (ackFire) begin
      next_activeLevel[callLevel] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeLevel <= 2'b00;
    end else begin
      activeLevel <= next_activeLevel;
    end
  end

  // one-cycle flag clears on acknowledge; all other flags untouched
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr0FlagClear <= 1'b0;
      tmr1FlagClear <= 1'b0;
      ext0FlagClear <= 1'b0;
      ext1FlagClear <= 1'b0;
    end else begin
      // converter done flag has no clear output, left to software: RULE_14
      tmr0FlagClear <= ackFire && (callSource == SRC_TMR0); // RULE_04 RULE_06
      tmr1FlagClear <= ackFire && (callSource == SRC_TMR1); // RULE_04 RULE_06
      ext0FlagClear <= ackFire && (callSource == SRC_EXT0) && ext0EdgeMode; // RULE_05
      ext1FlagClear <= ackFire && (callSource == SRC_EXT1) && ext1EdgeMode; // RULE_05
    end
  end

  // ahb-lite: one wait state, the write lands in the data phase
  assign addrAccept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
  assign regWrite = dataPhase && dataWrite;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr <= 8'h00;
      hreadyout <= 1'b1;
    end else if (dataPhase) begin
      dataPhase <= 1'b0;
      hreadyout <= 1'b1;
    end else if (addrAccept) begin
      dataPhase <= 1'b1;
      dataWrite <= hwrite;
      dataAddr <= haddr[7:0];
      hreadyout <= 1'b0;
    end
  end

  // every transfer completes with an okay response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // read mux, reserved and unmapped read as zero
  always_comb begin
    unique case (dataAddr)
      OFS_ENABLE_PRIMARY: readByte = enablePrimary;
      OFS_PRIORITY_PRIMARY: readByte = priorityPrimary;
      OFS_ENABLE_TIMER2: readByte = enableTimer2;
      OFS_TIMER2_CONTROL: readByte = timer2Control;
      OFS_IRQ_STATUS: readByte = {5'h00, irqStatus};
      OFS_IRQ_MASK: readByte = {5'h00, irqMask};
      OFS_ACTIVE_STATE: readByte = {callSource, 1'b0, callRequest, activeLevel};
      default: readByte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (dataPhase && !dataWrite) begin
      hrdata <= {24'h000000, readByte};
    end
  end

  // primary enable register, global gate and per-source enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enablePrimary <= RST_BYTE;
    end else if (regHit(OFS_ENABLE_PRIMARY)) begin
      enablePrimary <= hwdata[7:0]; // RULE_08 RULE_09
    end
  end

  // primary priority register, reserved bit kept zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      priorityPrimary <= RST_BYTE;
    end else if (regHit(OFS_PRIORITY_PRIMARY)) begin
      priorityPrimary <= hwdata[7:0] & PRIO_WRITE_MASK; // RULE_12
    end
  end

  // timer2 enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enableTimer2 <= RST_BYTE;
    end else if (regHit(OFS_ENABLE_TIMER2)) begin
      enableTimer2 <= hwdata[7:0]; // RULE_10
    end
  end

  // event mask register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= RST_STATUS;
    end else if (regHit(OFS_IRQ_MASK)) begin
      irqMask <= hwdata[ST_W-1:0];
    end
  end

  // timer2 control; hardware setting of the byte flag beats a software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer2Control <= RST_BYTE;
    end else begin
      if (regHit(OFS_TIMER2_CONTROL)) begin
        timer2Control <= hwdata[7:0];
      end
      if (t2ByteOverflowEvent) begin
        timer2Control[T2C_BYTE_FLAG_BIT] <= 1'b1; // RULE_13 RULE_06
      end
    end
  end

  // sticky event status, write one to clear, set wins
  assign statusSet = {t2ByteOverflowEvent, retiDone, ackFire};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= RST_STATUS;
    end else if (regHit(OFS_IRQ_STATUS)) begin
      irqStatus <= (irqStatus & ~hwdata[ST_W-1:0]) | statusSet;
    end else begin
      irqStatus <= irqStatus | statusSet;
    end
  end

  // registered interrupt line, high while an unmasked event is pending
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // timer2 configuration copy toward the timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t2Config <= RST_BYTE;
    end else begin
      t2Config <= timer2Control;
    end
  end

endmodule

// ==== testbench/iep_core_model.sv ====
// cpu core stand-in: takes forced calls and returns from them
`timescale 1ns/1ps
module iep_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // controller side
  input wire logic callRequest,
  input wire logic retiCmd,
  input wire logic [3:0] lat,
  output logic callTaken,
  output logic retiDone
);
  logic [3:0] waitCnt;
  logic [3:0] depth;
  // take a call after lat cycles, return on command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
      callTaken <= 1'b0;
      retiDone <= 1'b0;
      depth <= 4'h0;
    end else begin
      callTaken <= callRequest && !callTaken && waitCnt >= lat;
      waitCnt <= (callRequest && !callTaken) ? waitCnt + 4'h1 : 4'h0;
      retiDone <= retiCmd;
      // pc pushed on call, popped on return
      depth <= depth + {3'h0, callTaken} - {3'h0, retiDone};
    end
  end
endmodule

// ==== testbench/iep_interrupt_ctrl_sva.sv ====
// port-level checks of the interrupt controller
`timescale 1ns/1ps
module iep_interrupt_ctrl_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic ext0EdgeMode,
  input wire logic ext1EdgeMode,
  input wire logic tmr0FlagClear,
  input wire logic tmr1FlagClear,
  input wire logic ext0FlagClear,
  input wire logic ext1FlagClear,
  input wire logic callTaken,
  input wire logic retiDone,
  input wire logic callRequest,
  input wire logic [15:0] callVector,
  input wire logic [iep_pkg::SRC_W-1:0] callSource,
  input wire logic [1:0] activeLevel,
  input wire logic machineCycleStart
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_cyc; machineCycleStart |-> ##12 machineCycleStart; endproperty
  a_cyc: assert property (p_cyc) else $error("machine cycle not 12");
  property p_poll; $rose(callRequest) |-> $past(machineCycleStart); endproperty
  a_poll: assert property (p_poll) else $error("call off poll");
  property p_vec; callRequest |-> callVector == 16'h0003 + {9'h0, callSource, 3'h0}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_hold; callRequest && !callTaken |=> callRequest && $stable(callVector); endproperty
  a_hold: assert property (p_hold) else $error("call dropped");
  property p_take; callRequest && callTaken |=> !callRequest && activeLevel != 2'h0; endproperty
  a_take: assert property (p_take) else $error("take failed");
  property p_tmr;
    {tmr1FlagClear, tmr0FlagClear} == $past({callRequest && callTaken && callSource == 4'h3,
      callRequest && callTaken && callSource == 4'h1});
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer clear wrong");
  property p_x0;
    ext0FlagClear == $past(callRequest && callTaken && callSource == 4'h0 && ext0EdgeMode);
  endproperty
  a_x0: assert property (p_x0) else $error("ext0 clear wrong");
  property p_x1;
    ext1FlagClear == $past(callRequest && callTaken && callSource == 4'h2 && ext1EdgeMode);
  endproperty
  a_x1: assert property (p_x1) else $error("ext1 clear wrong");
  property p_return_from_interrupt; retiDone && !callTaken && activeLevel == 2'h1 |=> activeLevel == 2'h0; endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("level kept");
  property p_pre; $rose(callRequest) |-> !$past(activeLevel[1]); endproperty
  a_pre: assert property (p_pre) else $error("high preempted");
endmodule
bind iep_interrupt_ctrl iep_interrupt_ctrl_sva iep_interrupt_ctrl_sva_i (.sys_clk, .rst_n,
  .ext0EdgeMode, .ext1EdgeMode, .tmr0FlagClear, .tmr1FlagClear, .ext0FlagClear,
  .ext1FlagClear, .callTaken, .retiDone,
  .callRequest, .callVector, .callSource, .activeLevel, .machineCycleStart);

// ==== testbench/tb_interrupt_enable_priority_ack.sv ====
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
module tb_interrupt_enable_priority_ack;
  import iep_pkg::*;
  logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rdPh = 0, crSeen = 0, retiCmd = 0;
  logic pollBlocked = 0, ext0EdgeMode = 0, ext1EdgeMode = 0, t2Byte = 0;
  logic hreadyout, hresp, callRequest, callTaken, retiDone, irq, machineCycleStart;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, activeLevel;
  logic [2:0] hsize = 3'h2;
  logic [15:0] callVector;
  logic [3:0] callSource, lat = 0;
  logic [7:0] t2Config;
  logic [14:0] flg = 0;
  logic [31:0] r;
  logic [31:0] rdQ[$], vecQ[$];
  int err_total = 0, total_checks = 0;
  iep_interrupt_ctrl iep_interrupt_ctrl_i (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ext0Flag(flg[0]),
    .tmr0Flag(flg[1]), .ext1Flag(flg[2]), .tmr1Flag(flg[3]), .asyncSerialFlag(flg[4]),
    .twowireFlag(flg[5]), .converterDoneFlag(flg[6]), .t2CaptureFlag(flg[10:7]),
    .t2MatchFlag(flg[13:11]), .t2WideOverflowFlag(flg[14]), .t2ByteOverflowEvent(t2Byte),
    .ext0EdgeMode, .ext1EdgeMode, .tmr0FlagClear(), .tmr1FlagClear(), .ext0FlagClear(),
    .ext1FlagClear(), .pollBlocked, .callTaken, .retiDone, .callRequest, .callVector,
    .callSource, .activeLevel, .machineCycleStart, .t2Config, .irq);
  iep_core_model iep_core_model_i (.sys_clk, .rst_n, .callRequest, .retiCmd, .lat,
    .callTaken, .retiDone);
  // clock
  always #25 sys_clk = ~sys_clk;
  task automatic tally_and_finish(input bit hung);
    if (hung) err_total++;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single ahb transfer, waits on hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) tally_and_finish(1);
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !w;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rdPh <= 1'b0;
    if (n >= 100) tally_and_finish(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic waitCr(input logic v);
    int n;
    n = 0;
    while (callRequest !== v) begin
      @(posedge sys_clk);
      if (++n > 200) tally_and_finish(1);
    end
  endtask
  // expect a call from src and let the core take it
  task automatic serve(input logic [3:0] s);
    vecQ.push_back({16'h0000, VEC_BASE + {9'h0, s, 3'h0}});
    lat <= 4'($urandom_range(0, 9));
    waitCr(1'b1);
    waitCr(1'b0);
  endtask
  task automatic return_from_interrupt(input int mc);
    @(posedge sys_clk);
    retiCmd <= 1'b1;
    @(posedge sys_clk);
    retiCmd <= 1'b0;
    repeat (12 * mc) @(posedge sys_clk);
  endtask
  // results checked in order of appearance
  always @(posedge sys_clk) begin
    if (rdPh && hreadyout === 1'b1) cmp("hrdata", rdQ.pop_front(), hrdata);
    if (rdPh && hreadyout === 1'b1) cmp("hresp", 32'h0, {31'h0, hresp});
    if (callRequest === 1'b1 && !crSeen)
      cmp("vector", vecQ.size() ? vecQ.pop_front() : 32'hDEAD, {16'h0, callVector});
    crSeen <= callRequest;
  end
  // main sequence
  initial begin
    void'($urandom(32'h1514));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (r[i]) if (i < 8) rd(8'({4'hA + i[3:0], 4'h8}), 32'h0);
    r = $urandom;
    bus(1'b1, OFS_ENABLE_PRIMARY, r);
    bus(1'b1, OFS_PRIORITY_PRIMARY, r);
    bus(1'b1, 8'h10, r);
    rd(OFS_ENABLE_PRIMARY, r & 32'hFF);
    rd(OFS_PRIORITY_PRIMARY, r & 32'h7F);
    rd(8'h10, 32'h0);
    bus(1'b1, OFS_PRIORITY_PRIMARY, 32'h0);
    bus(1'b1, OFS_ENABLE_PRIMARY, 32'h7F);
    bus(1'b1, OFS_ENABLE_TIMER2, 32'hFF);
    flg <= 15'h7FFF;
    repeat (36) @(posedge sys_clk);
    bus(1'b1, OFS_ENABLE_TIMER2, 32'h0);
    bus(1'b1, OFS_ENABLE_PRIMARY, 32'h80);
    repeat (36) @(posedge sys_clk);
    flg <= 15'h0;
    // let the cleared flags be sampled before any source is enabled
    repeat (12) @(posedge sys_clk);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    bus(1'b1, OFS_TIMER2_CONTROL, 32'hC0);
    ext0EdgeMode <= 1'b1;
    ext1EdgeMode <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      bus(1'b1, OFS_ENABLE_PRIMARY, (i < 7) ? (32'h80 | (32'h1 << i)) : 32'h80);
      bus(1'b1, OFS_ENABLE_TIMER2, (i < 7) ? 32'h0 : (32'h1 << (i - 7)));
      flg[i] <= 1'b1;
      serve(4'(i));
      flg[i] <= 1'b0;
      return_from_interrupt(1);
    end
    rd(OFS_IRQ_STATUS, 32'h3);
    cmp("irq", 32'h1, {31'h0, irq});
    bus(1'b1, OFS_IRQ_STATUS, 32'h7);
    rd(OFS_IRQ_STATUS, 32'h0);
    cmp("irq", 32'h0, {31'h0, irq});
    bus(1'b1, OFS_PRIORITY_PRIMARY, 32'h08);
    bus(1'b1, OFS_ENABLE_PRIMARY, 32'h8F);
    ext0EdgeMode <= 1'b0;
    flg <= 15'h0005;
    serve(SRC_EXT0);
    flg <= 15'h000C;
    serve(SRC_TMR1);
    cmp("level", 32'h3, {30'h0, activeLevel});
    flg <= 15'h0004;
    repeat (24) @(posedge sys_clk);
    return_from_interrupt(2);
    return_from_interrupt(0);
    serve(SRC_EXT1);
    flg <= 15'h0;
    return_from_interrupt(0);
    pollBlocked <= 1'b1;
    flg <= 15'h0002;
    repeat (24) @(posedge sys_clk);
    flg <= 15'h0;
    // block lifts only after the vanished flag has been sampled
    repeat (12) @(posedge sys_clk);
    pollBlocked <= 1'b0;
    repeat (36) @(posedge sys_clk);
    @(posedge sys_clk);
    t2Byte <= 1'b1;
    @(posedge sys_clk);
    t2Byte <= 1'b0;
    serve(4'hE);
    rd(OFS_TIMER2_CONTROL, 32'hD0);
    cmp("t2Config", 32'hD0, {24'h0, t2Config});
    rd(OFS_IRQ_STATUS, 32'h7);
    tally_and_finish(0);
  end
endmodule
